// ==== design/dart_map.vh ====
// Register map and constants of the dual auto-reload 8-bit timer block.
// Assumes a 32-bit APB slave; offsets are byte addresses.
`ifndef DART_MAP_VH
`define DART_MAP_VH
`define DART_OFS_BAUD_COUNTER 12'h000
`define DART_OFS_BAUD_RELOAD 12'h004
`define DART_OFS_BAUD_CONTROL 12'h008
`define DART_OFS_PIN_COUNTER 12'h010
`define DART_OFS_PIN_RELOAD 12'h014
`define DART_OFS_PIN_CONTROL 12'h018
`define DART_OFS_IRQ_STATUS 12'h020
`define DART_OFS_IRQ_ENABLE 12'h024
`define DART_OFS_IRQ_PRIO 12'h028
`define DART_OFS_IRQ_VECTOR 12'h02C
`define DART_CTL_SEL_LSB 0
`define DART_CTL_SEL_MSB 2
`define DART_CTL_RUN 3
`define DART_CTL_OUT 7
`define DART_CTL_RESET 8'h70
`define DART_CTL_ONES 8'h70
`define DART_VEC_BAUD 16'h0026
`define DART_VEC_PIN 16'h0036
`define DART_PRESC_W 8
`endif

// ==== design/dart_timer_pair.v ====
// Two 8-bit auto-reload up-counting timers behind an APB slave.
// Assumes a 40 MHz clk, synchronous active-high rst and a free-running
// timebase count clock enable pulse from outside.
//
// What this block does
// - 8-bit up-counter; overflow reloads and requests interrupt
// - Counter write also loads reload register
// - Reload register 8-bit, read/write, copied on overflow
// - Control bits 0-2 choose prescaled count clock
// - Run bit 3 starts and halts counting
// - Bit 7 output level, inverted each overflow
// - Control bits 4-6 ignore writes, read one
// - Reset sets baud timer control to 70H
// - Reset sets pin timer control to 70H
// - Counter and reload not reset
// - Overflow cycle repeats while run stays set
// - Baud timer overflow clocks serial unit six
// - Pin timer overflow clocks serial unit one
// - Pin timer output bit drives a pin
// - Baud overflow sets request flag, register one
// - Enable gates request; two bits pick priority
// - Baud timer interrupt vector is 0026H
// - Baud timer output bit is flag only
// - Pin overflow flags register two, vector 0036H
`include "dart_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dart_timer_pair #(
   // Divide exponent per select code, 4 bits each, code 0 in low nibble;
   // 4'hF marks a prohibited code that never ticks
   parameter [31:0] SEL_TABLE = 32'hFF85_3210
) (
   input wire clk, // 40 MHz clock
   input wire rst, // Synchronous reset, active high
   input wire timebase_count_clock, // Timebase tick, one-cycle pulse
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction
   input wire [11:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error, unmapped address
   output reg serial_unit_six_baud, // Baud tick from baud timer
   output reg serial_unit_one_baud, // Baud tick from pin timer
   output reg port8_line4, // Pin timer output level
   output reg baud_timer_irq_req, // Gated request, baud timer
   output reg pin_timer_irq_req, // Gated request, pin timer
   output reg [1:0] baud_timer_irq_prio, // Priority level, baud timer
   output reg [1:0] pin_timer_irq_prio // Priority level, pin timer
);

   // Shared prescaler of the timebase tick
   reg [`DART_PRESC_W-1:0] presc_reg;
   reg [`DART_PRESC_W-1:0] presc_next;
   wire [`DART_PRESC_W:0] presc_tick;

   // Per-timer state, index 0 baud timer, index 1 pin timer
   reg [7:0] counter_reg [0:1];
   reg [7:0] reload_reg [0:1];
   reg [7:0] control_reg [0:1];
   wire [1:0] ovf;
   wire [1:0] cnt_tick;

   // Interrupt flags and controls
   reg [1:0] irq_flag_reg;
   reg [1:0] irq_enable_reg;
   reg [3:0] irq_prio_reg;

   // APB decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_bc = (paddr == `DART_OFS_BAUD_COUNTER);
   wire hit_br = (paddr == `DART_OFS_BAUD_RELOAD);
   wire hit_bk = (paddr == `DART_OFS_BAUD_CONTROL);
   wire hit_pc = (paddr == `DART_OFS_PIN_COUNTER);
   wire hit_pr = (paddr == `DART_OFS_PIN_RELOAD);
   wire hit_pk = (paddr == `DART_OFS_PIN_CONTROL);
   wire hit_is = (paddr == `DART_OFS_IRQ_STATUS);
   wire hit_ie = (paddr == `DART_OFS_IRQ_ENABLE);
   wire hit_ip = (paddr == `DART_OFS_IRQ_PRIO);
   wire hit_iv = (paddr == `DART_OFS_IRQ_VECTOR);
   wire mapped = hit_bc | hit_br | hit_bk | hit_pc | hit_pr | hit_pk |
      hit_is | hit_ie | hit_ip | hit_iv;
   wire [1:0] wr_cnt = {wr & hit_pc, wr & hit_bc};
   wire [1:0] wr_rld = {wr & hit_pr, wr & hit_br};
   wire [1:0] wr_ctl = {wr & hit_pk, wr & hit_bk};

   // Prescaler: bit k of presc_tick pulses once per 2^k timebase ticks
   always @* begin
      presc_next = presc_reg;
      if (timebase_count_clock)
         presc_next = presc_reg + 8'h01;
   end

   always @(posedge clk) begin
      if (rst)
         presc_reg <= {`DART_PRESC_W{1'b0}};
      else
         presc_reg <= presc_next;
   end

   genvar k;
   generate
      assign presc_tick[0] = timebase_count_clock;
      for (k = 1; k <= `DART_PRESC_W; k = k + 1) begin : g_tick
         assign presc_tick[k] = timebase_count_clock &
            (presc_reg[k-1:0] == {k{1'b1}});
      end
   endgenerate

   // Both timers share one body; only wiring of their outputs differs
   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1) begin : g_tmr
         wire [2:0] sel = control_reg[t][`DART_CTL_SEL_MSB:`DART_CTL_SEL_LSB];
         wire [3:0] expo = SEL_TABLE[sel*4 +: 4];
         // Prohibited codes select nothing, so the counter stays put
         wire tick_src = (expo <= 4'h8) ? presc_tick[expo] : 1'b0;
         assign cnt_tick[t] = tick_src & control_reg[t][`DART_CTL_RUN];
         assign ovf[t] = cnt_tick[t] & (counter_reg[t] == 8'hFF);

         // Counter: software write wins over counting in the same cycle
         always @(posedge clk) begin
            if (wr_cnt[t])
               counter_reg[t] <= pwdata[7:0];
            else if (ovf[t])
               counter_reg[t] <= reload_reg[t];
            else if (cnt_tick[t])
               counter_reg[t] <= counter_reg[t] + 8'h01;
         end

         // Reload has no reset value; counter write mirrors into it
         always @(posedge clk) begin
            if (wr_rld[t] | wr_cnt[t])
               reload_reg[t] <= pwdata[7:0];
         end

         // Control: bits 4-6 fixed at one; overflow inverts output bit
         always @(posedge clk) begin
            if (rst)
               control_reg[t] <= `DART_CTL_RESET;
            else if (wr_ctl[t])
               control_reg[t] <= (pwdata[7:0] & ~`DART_CTL_ONES) |
                  `DART_CTL_ONES;
            else if (ovf[t])
               control_reg[t][`DART_CTL_OUT] <=
                  ~control_reg[t][`DART_CTL_OUT];
         end
      end
   endgenerate

   // Sticky flags: an overflow beats a clear in the same cycle
   always @(posedge clk) begin
      if (rst)
         irq_flag_reg <= 2'h0;
      else if (wr & hit_is)
         irq_flag_reg <= (irq_flag_reg & ~pwdata[1:0]) | ovf;
      else
         irq_flag_reg <= irq_flag_reg | ovf;
   end

   // Enable and priority controls
   always @(posedge clk) begin
      if (rst) begin
         irq_enable_reg <= 2'h0;
         irq_prio_reg <= 4'h0;
      end else begin
         if (wr & hit_ie)
            irq_enable_reg <= pwdata[1:0];
         if (wr & hit_ip)
            irq_prio_reg <= pwdata[3:0];
      end
   end

   // Outputs all registered; baud ticks lag overflow by one cycle
   always @(posedge clk) begin
      if (rst) begin
         serial_unit_six_baud <= 1'b0;
         serial_unit_one_baud <= 1'b0;
         port8_line4 <= 1'b0;
         baud_timer_irq_req <= 1'b0;
         pin_timer_irq_req <= 1'b0;
         baud_timer_irq_prio <= 2'h0;
         pin_timer_irq_prio <= 2'h0;
      end else begin
         serial_unit_six_baud <= ovf[0];
         serial_unit_one_baud <= ovf[1];
         // Only the pin timer reaches a pin; baud output stays internal
         port8_line4 <= control_reg[1][`DART_CTL_OUT];
         baud_timer_irq_req <= irq_flag_reg[0] & irq_enable_reg[0];
         pin_timer_irq_req <= irq_flag_reg[1] & irq_enable_reg[1];
         baud_timer_irq_prio <= irq_prio_reg[1:0];
         pin_timer_irq_prio <= irq_prio_reg[3:2];
      end
   end

   // APB slave: one wait-free access phase, read data registered
   always @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            if (hit_bc)
               prdata <= {24'h000000, counter_reg[0]};
            else if (hit_br)
               prdata <= {24'h000000, reload_reg[0]};
            else if (hit_bk)
               prdata <= {24'h000000, control_reg[0]};
            else if (hit_pc)
               prdata <= {24'h000000, counter_reg[1]};
            else if (hit_pr)
               prdata <= {24'h000000, reload_reg[1]};
            else if (hit_pk)
               prdata <= {24'h000000, control_reg[1]};
            else if (hit_is)
               prdata <= {30'h00000000, irq_flag_reg};
            else if (hit_ie)
               prdata <= {30'h00000000, irq_enable_reg};
            else if (hit_ip)
               prdata <= {28'h0000000, irq_prio_reg};
            else if (hit_iv)
               prdata <= {`DART_VEC_PIN, `DART_VEC_BAUD};
         end
      end
   end

endmodule // dart_timer_pair
`default_nettype wire

// ==== verif/dart_chk.sv ====
// Checker for the dual timer: APB handshake, baud ticks, requests.
// Assumes it is bound to dart_timer_pair and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dart_chk (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic timebase_count_clock, // Tick
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic serial_unit_six_baud, // Baud tick six
   input wire logic serial_unit_one_baud, // Baud tick one
   input wire logic port8_line4, // Output pin
   input wire logic baud_timer_irq_req // Request
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // A write may legally move a request or the pin, so it is excluded
   wire logic wr = psel && penable && pwrite;
   chk_ready_setup:
      assert property (psel && !penable |=> pready) else $error("no ready");
   chk_ready_pulse:
      assert property (pready |=> !pready) else $error("ready held");
   chk_err_ready:
      assert property (pslverr |-> pready) else $error("error alone");
   chk_reset_quiet:
      assert property ($fell(rst) |-> !pready && !port8_line4 &&
         !serial_unit_six_baud && !baud_timer_irq_req) else $error("reset");
   chk_tick_cause:
      assert property (serial_unit_six_baud || serial_unit_one_baud |->
         $past(timebase_count_clock)) else $error("baud without tick");
   chk_pin_toggle:
      assert property (serial_unit_one_baud && !$past(wr) |=>
         port8_line4 != $past(port8_line4)) else $error("pin not toggled");
   chk_irq_cause:
      assert property ($rose(baud_timer_irq_req) |->
         $past(serial_unit_six_baud) || $past(wr, 2))
         else $error("stray request");
   // A clear lands one cycle before the request output follows it
   chk_irq_sticky:
      assert property (baud_timer_irq_req && !wr && !$past(wr) |=>
         baud_timer_irq_req) else $error("request dropped");
   cover property (serial_unit_six_baud);
   cover property (serial_unit_one_baud);
   cover property (pslverr);
endmodule // dart_chk
bind dart_timer_pair dart_chk u_chk (.clk, .rst, .timebase_count_clock,
   .psel, .penable, .pwrite, .pready, .pslverr, .serial_unit_six_baud,
   .serial_unit_one_baud, .port8_line4, .baud_timer_irq_req);
`default_nettype wire

// ==== verif/dart_serial_model.sv ====
// Stand-in for both serial units: counts the baud ticks they receive.
// Assumes one-cycle tick pulses in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module dart_serial_model (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic baud_six, // Tick into unit six
   input wire logic baud_one, // Tick into unit one
   output var int six_count, // Ticks seen by unit six
   output var int one_count // Ticks seen by unit one
);
   // One tick is one bit time; the units only need the count
   always @(posedge clk) begin
      if (rst) begin
         six_count <= 0;
         one_count <= 0;
      end else begin
         six_count <= six_count + int'(baud_six);
         one_count <= one_count + int'(baud_one);
      end
   end
endmodule // dart_serial_model
`default_nettype wire

// ==== verif/test_dart_timer_pair.sv ====
// Bench for the dual timer: APB register tests and timer runs.
// Assumes the map header is on the include path.
`include "dart_map.vh"
`timescale 1ns/1ps
`default_nettype none
module test_dart_timer_pair;
   logic clk = 0, rst = 1, tick = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, six, one, pin, irq_b, irq_p, err;
   logic [1:0] pr_b, pr_p;
   int six_count, one_count, seen, n_mismatch = 0, num_checks = 0;
   dart_timer_pair dut (.clk(clk), .rst(rst), .timebase_count_clock(tick),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_unit_six_baud(six), .serial_unit_one_baud(one),
      .port8_line4(pin), .baud_timer_irq_req(irq_b),
      .pin_timer_irq_req(irq_p), .baud_timer_irq_prio(pr_b),
      .pin_timer_irq_prio(pr_p));
   dart_serial_model far (.clk(clk), .rst(rst), .baud_six(six),
      .baud_one(one), .six_count(six_count), .one_count(one_count));
   initial forever #12.5 clk = ~clk;
   // Tick every other cycle so the divider sees gaps
   always @(posedge clk) tick <= ~tick;
   // One transfer; the leading edge keeps release and setup apart
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0);
      cmp("read", exp, rd);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog: the whole run needs well under 1000 cycles
   initial begin
      #(2000 * 25);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      rdc(`DART_OFS_BAUD_CONTROL, 32'h70);
      rdc(`DART_OFS_PIN_CONTROL, 32'h70);
      apb(1, `DART_OFS_BAUD_CONTROL, 32'h85);
      rdc(`DART_OFS_BAUD_CONTROL, 32'hF5);
      apb(1, `DART_OFS_BAUD_COUNTER, 32'hFC);
      rdc(`DART_OFS_BAUD_RELOAD, 32'hFC);
      apb(1, `DART_OFS_PIN_COUNTER, 32'hFA);
      apb(1, `DART_OFS_PIN_RELOAD, 32'hFC);
      rdc(`DART_OFS_PIN_RELOAD, 32'hFC);
      rdc(`DART_OFS_PIN_COUNTER, 32'hFA);
      rdc(12'h030, 32'h0);
      cmp("slverr", 1, err);
      rdc(`DART_OFS_IRQ_VECTOR, 32'h00360026);
      apb(1, `DART_OFS_IRQ_ENABLE, 32'h1);
      apb(1, `DART_OFS_IRQ_PRIO, 32'hE);
      apb(1, `DART_OFS_PIN_CONTROL, 32'h08);
      cmp("prio", 4'hE, {pr_p, pr_b});
      apb(1, `DART_OFS_BAUD_CONTROL, 32'h88);
      seen = 0;
      while (one !== 1'b1 && seen < 200) begin
         @(posedge clk);
         seen++;
      end
      // The pin follows the baud tick by one more cycle
      @(posedge clk);
      cmp("pin", 1, pin);
      repeat (100) @(posedge clk);
      cmp("six", 1, six_count > 4);
      cmp("one", 1, one_count > 4);
      cmp("req", 2'b01, {irq_p, irq_b});
      rdc(`DART_OFS_IRQ_STATUS, 32'h3);
      apb(1, `DART_OFS_PIN_CONTROL, 32'h00);
      apb(1, `DART_OFS_BAUD_CONTROL, 32'h00);
      repeat (3) @(posedge clk);
      seen = six_count + one_count;
      repeat (40) @(posedge clk);
      cmp("halt", seen, six_count + one_count);
      apb(1, `DART_OFS_IRQ_STATUS, 32'h3);
      rdc(`DART_OFS_IRQ_STATUS, 32'h0);
      tally_and_finish;
   end
endmodule // test_dart_timer_pair
`default_nettype wire
